// ### ccpc_regs.vh
// register map, field positions and reset values of the capture/compare/pwm channel pair
`ifndef CCPC_REGS_VH
`define CCPC_REGS_VH

// ----------------------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------------------
`define CCPC_OFF_CHAN4_CONTROL    6'h00
`define CCPC_OFF_CHAN4_VALUE_LOW  6'h04
`define CCPC_OFF_CHAN4_VALUE_HIGH 6'h08
`define CCPC_OFF_CHAN5_CONTROL    6'h0C
`define CCPC_OFF_CHAN5_VALUE_LOW  6'h10
`define CCPC_OFF_CHAN5_VALUE_HIGH 6'h14
`define CCPC_OFF_TIMER_ONE_CTRL   6'h18
`define CCPC_OFF_TIMER_THREE_CTRL 6'h1C
`define CCPC_OFF_TIMER_ONE_LOW    6'h20
`define CCPC_OFF_TIMER_ONE_SHARED 6'h24
`define CCPC_OFF_ALT_SELECT       6'h28
`define CCPC_OFF_IRQ_STATUS       6'h2C
`define CCPC_CHAN_STRIDE          6'h0C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CCPC_CTL_MODE_MSB         3
`define CCPC_CTL_DUTY_LO          4
`define CCPC_CTL_DUTY_HI          5
`define CCPC_CTL_IMPL_MASK        8'h3F
`define CCPC_T3_ASSIGN_HI         6
`define CCPC_T3_ASSIGN_LO         3
`define CCPC_ALT_SELECT_BIT       0
`define CCPC_STAT_FLAG_LSB        0
`define CCPC_STAT_ENABLE_LSB      2
`define CCPC_OD_CHAN4_BIT         3
`define CCPC_OD_CHAN5_BIT         4
`define CCPC_OD_IMPL_MASK         8'h1F

// ----------------------------------------------------------------------------
// mode encodings
// ----------------------------------------------------------------------------
`define CCPC_MODE_OFF             4'h0
`define CCPC_MODE_TOGGLE          4'h2
`define CCPC_MODE_CAP_FALL        4'h4
`define CCPC_MODE_CAP_RISE        4'h5
`define CCPC_MODE_CAP_RISE4       4'h6
`define CCPC_MODE_CAP_RISE16      4'h7
`define CCPC_MODE_SET_ON_MATCH    4'h8
`define CCPC_MODE_CLR_ON_MATCH    4'h9
`define CCPC_MODE_SOFT_IRQ        4'hA
`define CCPC_MODE_SPECIAL_EVENT   4'hB

// ----------------------------------------------------------------------------
// reset values and prescaler counts
// ----------------------------------------------------------------------------
`define CCPC_RST_BYTE             8'h00
`define CCPC_RST_VALUE            16'h0000
`define CCPC_PRESC_LAST4          4'h3
`define CCPC_PRESC_LAST16         4'hF

`endif

// ### ccpc_top.v
// two capture/compare/pwm channels with an avalon-mm register slave
//
// Overview of operation
// R1: compare value continuously checked against selected timer
// R2: match drives high, low, toggles or keeps pin
// R3: match sets interrupt flag with pin action
// R4: mode 1010 touches no pin, only flag
// R5: control write of zero forces output latch low
// R6: software sets pin direction output for compare
// R7: feeding timer must run synchronously
// R8: software clears control before changing prescaler
// R9: pwm duty cycle has ten bit resolution
// R10: software clears direction bit for pwm output
// R11: control clear in pwm forces latch low
// R12: timer one bytes visible when select zero
// R13: open drain register visible when select one
// R14: control upper two bits read zero
// R15: mode field decodes off, compare, capture, pwm
// R16: mode 1011 match raises special event pulse
// R17: capture copies timer, sets flag, overwrites
// R18: prescaler cleared when off, not capturing, reset
// R19: match is one pulse on first equality
// R20: flag sticky until cleared, match sets again
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "ccpc_regs.vh"

module ccpc_top (
  input  wire        mclk,
  input  wire        reset,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [15:0] timer_one_count,
  input  wire [15:0] timer_three_count,
  input  wire [9:0]  pwm_timebase,
  input  wire        pwm_period_match,
  input  wire [1:0]  port_g_direction,
  input  wire [1:0]  port_g_latch,
  input  wire [1:0]  chan_pin_in,
  output reg  [1:0]  chan_pin_out,
  output reg  [1:0]  chan_pin_oe_n,
  output reg  [1:0]  chan_irq,
  output reg  [1:0]  special_event
);

  // --------------------------------------------------------------------------
  // mode decoding
  // --------------------------------------------------------------------------
  function is_capture;
    input [3:0] mode;
    begin
      is_capture = (mode[3:2] == 2'b01);
    end
  endfunction

  function is_compare;
    input [3:0] mode;
    begin
      is_compare = (mode == `CCPC_MODE_TOGGLE) || (mode[3:2] == 2'b10);
    end
  endfunction

  function is_pwm;
    input [3:0] mode;
    begin
      is_pwm = (mode[3:2] == 2'b11);
    end
  endfunction

  // channel drives the pin itself rather than passing the port latch through
  function drives_pin;
    input [3:0] mode;
    begin
      drives_pin = is_pwm(mode) || (is_compare(mode) && mode != `CCPC_MODE_SOFT_IRQ
                   && mode != `CCPC_MODE_SPECIAL_EVENT);
    end
  endfunction

  // --------------------------------------------------------------------------
  // shared registers and bus handshake
  // --------------------------------------------------------------------------
  reg  [7:0]  timer_one_control_r;
  reg  [7:0]  timer_three_control_r;
  reg  [7:0]  open_drain_config_r;
  reg         alt_reg_select_r;
  reg  [1:0]  match_irq_enable_r;
  reg  [7:0]  ctl_r [0:1];
  reg  [15:0] val_r [0:1];
  reg  [1:0]  match_irq_flag_r;
  reg  [1:0]  out_r;
  reg  [1:0]  pin_sync1_r;
  reg  [1:0]  pin_sync2_r;
  reg  [1:0]  pin_prev_r;

  wire        bus_req   = avs_read | avs_write;
  wire        bus_do    = bus_req & ~avs_waitrequest;
  wire        wr_lane0  = avs_write & bus_do & avs_byteenable[0];
  wire [5:0]  word_addr = {avs_address[5:2], 2'b00};
  wire [7:0]  wdata     = avs_writedata[7:0];
  // timers 3 feeds both channels whenever either assignment bit is set
  wire        use_t3    = timer_three_control_r[`CCPC_T3_ASSIGN_HI]
                        | timer_three_control_r[`CCPC_T3_ASSIGN_LO];
  wire [15:0] sel_timer = use_t3 ? timer_three_count : timer_one_count;   // [R1]

  reg  [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (word_addr)
      `CCPC_OFF_CHAN4_CONTROL:    rd_mux[7:0] = ctl_r[0] & `CCPC_CTL_IMPL_MASK;   // [R14]
      `CCPC_OFF_CHAN4_VALUE_LOW:  rd_mux[7:0] = val_r[0][7:0];
      `CCPC_OFF_CHAN4_VALUE_HIGH: rd_mux[7:0] = val_r[0][15:8];
      `CCPC_OFF_CHAN5_CONTROL:    rd_mux[7:0] = ctl_r[1] & `CCPC_CTL_IMPL_MASK;   // [R14]
      `CCPC_OFF_CHAN5_VALUE_LOW:  rd_mux[7:0] = val_r[1][7:0];
      `CCPC_OFF_CHAN5_VALUE_HIGH: rd_mux[7:0] = val_r[1][15:8];
      `CCPC_OFF_TIMER_ONE_CTRL:   rd_mux[7:0] = timer_one_control_r;
      `CCPC_OFF_TIMER_THREE_CTRL: rd_mux[7:0] = timer_three_control_r;
      `CCPC_OFF_TIMER_ONE_LOW:
        if (!alt_reg_select_r)
          rd_mux[7:0] = timer_one_count[7:0];                                  // [R12]
      `CCPC_OFF_TIMER_ONE_SHARED:
        if (alt_reg_select_r)
          rd_mux[7:0] = open_drain_config_r & `CCPC_OD_IMPL_MASK;              // [R13]
        else
          rd_mux[7:0] = timer_one_count[15:8];                                 // [R12]
      `CCPC_OFF_ALT_SELECT:       rd_mux[0] = alt_reg_select_r;
      `CCPC_OFF_IRQ_STATUS:
        rd_mux[3:0] = {match_irq_enable_r, match_irq_flag_r};
      default:                    rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait cycle: read data is registered together with the waitrequest drop
  always @(posedge mclk)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else if (bus_req && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      // writes leave the last read answer in place
      if (avs_read)
        avs_readdata <= rd_mux;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // shared configuration registers
  // --------------------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (reset)
    begin
      timer_one_control_r   <= `CCPC_RST_BYTE;
      timer_three_control_r <= `CCPC_RST_BYTE;
      open_drain_config_r   <= `CCPC_RST_BYTE;
      alt_reg_select_r      <= 1'b0;
      match_irq_enable_r    <= 2'b00;
    end
    else if (wr_lane0)
    begin
      case (word_addr)
        `CCPC_OFF_TIMER_ONE_CTRL:   timer_one_control_r   <= wdata;
        `CCPC_OFF_TIMER_THREE_CTRL: timer_three_control_r <= wdata;
        `CCPC_OFF_TIMER_ONE_SHARED:
          if (alt_reg_select_r)
            open_drain_config_r <= wdata & `CCPC_OD_IMPL_MASK;                 // [R13]
        `CCPC_OFF_ALT_SELECT:       alt_reg_select_r <= wdata[`CCPC_ALT_SELECT_BIT];
        `CCPC_OFF_IRQ_STATUS:
          match_irq_enable_r <= wdata[`CCPC_STAT_ENABLE_LSB+1:`CCPC_STAT_ENABLE_LSB];
        default:                    alt_reg_select_r <= alt_reg_select_r;
      endcase
    end
  end

  // capture pins come from outside: two flops before any logic looks at them
  always @(posedge mclk)
  begin
    if (reset)
    begin
      pin_sync1_r <= 2'b00;
      pin_sync2_r <= 2'b00;
      pin_prev_r  <= 2'b00;
    end
    else
    begin
      pin_sync1_r <= chan_pin_in;
      pin_sync2_r <= pin_sync1_r;
      pin_prev_r  <= pin_sync2_r;
    end
  end

  // --------------------------------------------------------------------------
  // per-channel logic
  // --------------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      wire [5:0] base    = (ch == 0) ? `CCPC_OFF_CHAN4_CONTROL : `CCPC_OFF_CHAN5_CONTROL;
      wire [5:0] a_low   = base + 6'h04;
      wire [5:0] a_high  = base + 6'h08;
      wire [3:0] mode    = ctl_r[ch][`CCPC_CTL_MODE_MSB:0];
      wire       od      = open_drain_config_r[`CCPC_OD_CHAN4_BIT + ch];
      wire       rise    = pin_sync2_r[ch] & ~pin_prev_r[ch];
      wire       fall    = ~pin_sync2_r[ch] & pin_prev_r[ch];
      wire       eq      = (sel_timer == val_r[ch]);
      wire       ctl_wr  = wr_lane0 && (word_addr == base);
      wire [3:0] wmode   = wdata[`CCPC_CTL_MODE_MSB:0];

      reg        eq_prev_r;
      reg  [3:0] presc_r;
      reg  [1:0] duty_lsb_latch_r;
      reg        cap_evt;
      reg  [3:0] presc_nxt;

      // one match per arrival at equality, not per cycle of it
      wire match = is_compare(mode) && eq && !eq_prev_r;                       // [R19]
      wire pwm_clear = is_pwm(mode) && ({val_r[ch][15:8], duty_lsb_latch_r} == pwm_timebase);

      always @*
      begin
        cap_evt   = 1'b0;
        presc_nxt = presc_r;
        case (mode)
          `CCPC_MODE_CAP_FALL:   cap_evt = fall;
          `CCPC_MODE_CAP_RISE:   cap_evt = rise;
          `CCPC_MODE_CAP_RISE4,
          `CCPC_MODE_CAP_RISE16:
            if (rise)
            begin
              if (presc_r == ((mode == `CCPC_MODE_CAP_RISE4) ?
                              `CCPC_PRESC_LAST4 : `CCPC_PRESC_LAST16))
              begin
                cap_evt   = 1'b1;
                presc_nxt = 4'h0;
              end
              else
                presc_nxt = presc_r + 4'h1;
            end
          default:               presc_nxt = 4'h0;                             // [R18]
        endcase
      end

      always @(posedge mclk)
      begin
        if (reset)
        begin
          ctl_r[ch]        <= `CCPC_RST_BYTE;
          val_r[ch]        <= `CCPC_RST_VALUE;
          out_r[ch]        <= 1'b0;
          eq_prev_r        <= 1'b0;
          presc_r          <= 4'h0;                                            // [R18]
          duty_lsb_latch_r <= 2'b00;
          match_irq_flag_r[ch] <= 1'b0;
          special_event[ch]    <= 1'b0;
          chan_irq[ch]         <= 1'b0;
          chan_pin_out[ch]     <= 1'b0;
          chan_pin_oe_n[ch]    <= 1'b1;
        end
        else
        begin
          eq_prev_r <= eq;
          // a control write restarts the prescaler; value zero also stops it
          presc_r   <= ctl_wr ? 4'h0 : presc_nxt;                              // [R18]

          if (ctl_wr)
            ctl_r[ch] <= wdata & `CCPC_CTL_IMPL_MASK;                          // [R14]

          // value register: bus writes, capture overwrites, pwm reloads high
          if (cap_evt)
            val_r[ch] <= sel_timer;                                            // [R17]
          else if (is_pwm(mode) && pwm_period_match)
            val_r[ch][15:8] <= val_r[ch][7:0];                                 // [R9]
          else if (wr_lane0 && word_addr == a_low)
            val_r[ch][7:0] <= wdata;
          else if (wr_lane0 && word_addr == a_high && !is_pwm(mode))
            val_r[ch][15:8] <= wdata;

          if (is_pwm(mode) && pwm_period_match)
            duty_lsb_latch_r <= ctl_r[ch][`CCPC_CTL_DUTY_HI:`CCPC_CTL_DUTY_LO];  // [R9]

          // output latch
          if (ctl_wr && wmode == `CCPC_MODE_OFF)
            out_r[ch] <= 1'b0;                                                 // [R5] [R11]
          else if (ctl_wr && wmode == `CCPC_MODE_SET_ON_MATCH)
            out_r[ch] <= 1'b0;
          else if (ctl_wr && wmode == `CCPC_MODE_CLR_ON_MATCH)
            out_r[ch] <= 1'b1;
          else if (match)
          begin
            case (mode)                                                        // [R2] [R15]
              `CCPC_MODE_TOGGLE:       out_r[ch] <= ~out_r[ch];
              `CCPC_MODE_SET_ON_MATCH: out_r[ch] <= 1'b1;
              `CCPC_MODE_CLR_ON_MATCH: out_r[ch] <= 1'b0;
              default:                 out_r[ch] <= out_r[ch];                 // [R4]
            endcase
          end
          else if (is_pwm(mode) && pwm_period_match)
            // a zero duty never raises the pin
            out_r[ch] <= (ctl_r[ch][`CCPC_CTL_DUTY_HI:`CCPC_CTL_DUTY_LO] != 2'b00)
                         || (val_r[ch][7:0] != 8'h00);
          else if (pwm_clear)
            out_r[ch] <= 1'b0;

          // sticky flag; an event in the clearing cycle wins
          if (match || cap_evt)
            match_irq_flag_r[ch] <= 1'b1;                                      // [R3] [R17] [R20]
          else if (wr_lane0 && word_addr == `CCPC_OFF_IRQ_STATUS
                   && wdata[`CCPC_STAT_FLAG_LSB + ch])
            match_irq_flag_r[ch] <= 1'b0;                                      // [R20]

          special_event[ch] <= match && (mode == `CCPC_MODE_SPECIAL_EVENT);    // [R16]
          chan_irq[ch]      <= match_irq_flag_r[ch] & match_irq_enable_r[ch];  // [R4]

          // pin: channel latch in driving modes, port latch otherwise
          if (drives_pin(mode))
          begin
            chan_pin_out[ch]  <= od ? 1'b0 : out_r[ch];
            chan_pin_oe_n[ch] <= port_g_direction[ch] | (od & out_r[ch]);      // [R6] [R10]
          end
          else
          begin
            chan_pin_out[ch]  <= port_g_latch[ch];                             // [R4]
            chan_pin_oe_n[ch] <= port_g_direction[ch];
          end
        end
      end
    end
  endgenerate

endmodule // ccpc_top

// ### ccpc_pin_model.sv
// outside circuit on the two channel pins
`timescale 1ns/1ps
module ccpc_pin_model (
  input  wire [1:0] pin_out,
  input  wire [1:0] pin_oe_n,
  input  wire [1:0] ext_level,
  output wire [1:0] pin_in
);
  // a released pin shows the outside source, never the last driven level
  assign pin_in = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule // ccpc_pin_model

// ### ccpc_top_sva.sv
// concurrent checks on the ports of the channel pair
`timescale 1ns/1ps
module ccpc_checker (
  input wire        mclk,
  input wire        reset,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [15:0] timer_one_count,
  input wire [15:0] timer_three_count,
  input wire [1:0]  port_g_direction,
  input wire [1:0]  chan_pin_oe_n,
  input wire [1:0]  chan_irq,
  input wire [1:0]  special_event
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  a_data_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_data_hold: assert property (!$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved without read");
  a_quiet_reset: assert property ($past(reset) |->
    chan_irq == 2'b00 && special_event == 2'b00 && chan_pin_oe_n == 2'b11)
    else $error("outputs not quiet after reset");
  a_pin_release: assert property (($past(port_g_direction) & ~chan_pin_oe_n) == 2'b00)
    else $error("pin driven while direction is input");
  a_event_pulse: assert property (special_event[0] |=> !special_event[0])
    else $error("special event longer than one cycle");
  // a match needs the timer to have just arrived at the compare value
  a_event_cause: assert property (special_event[0] |->
    $past(timer_one_count) != $past(timer_one_count, 2) ||
    $past(timer_three_count) != $past(timer_three_count, 2))
    else $error("special event without fresh match");
endmodule // ccpc_checker

bind ccpc_top ccpc_checker ccpc_checker_i (.mclk(mclk), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timer_one_count(timer_one_count), .timer_three_count(timer_three_count),
  .port_g_direction(port_g_direction), .chan_pin_oe_n(chan_pin_oe_n), .chan_irq(chan_irq),
  .special_event(special_event));

// ### ccpc_top_tb.sv
// self-checking bench for the channel pair
`timescale 1ns/1ps
module ccpc_top_tb;
  reg         mclk, reset, avs_read, avs_write, pwm_period_match;
  reg  [5:0]  avs_address;
  reg  [31:0] avs_writedata;
  reg  [3:0]  avs_byteenable;
  reg  [15:0] timer_one_count, timer_three_count;
  reg  [9:0]  pwm_timebase;
  reg  [1:0]  port_g_direction, port_g_latch, ext_level;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire [1:0]  chan_pin_in, chan_pin_out, chan_pin_oe_n, chan_irq, special_event;
  integer     error_cnt, check_count, ev_cnt, i;
  reg  [7:0]  rdat;

  ccpc_top ccpc_top_i (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_one_count(timer_one_count),
    .timer_three_count(timer_three_count), .pwm_timebase(pwm_timebase),
    .pwm_period_match(pwm_period_match), .port_g_direction(port_g_direction),
    .port_g_latch(port_g_latch), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
    .chan_pin_oe_n(chan_pin_oe_n), .chan_irq(chan_irq), .special_event(special_event));
  ccpc_pin_model ccpc_pin_model_i (.pin_out(chan_pin_out), .pin_oe_n(chan_pin_oe_n),
    .ext_level(ext_level), .pin_in(chan_pin_in));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (special_event[0] === 1'b1) ev_cnt <= ev_cnt + 1;

  // ---------------------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------------------
  task results;
  begin
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // a fresh edge before each request keeps strobes from being set twice in one step
  task bus(input rw, input [5:0] a, input [7:0] d);
    integer n;
  begin
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !rw;
    avs_write <= rw;
    n = 0;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
    begin
      n = n + 1;
      if (n > 20)
      begin
        error_cnt = error_cnt + 1;
        results;
      end
      @(posedge mclk);
    end
    rdat = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input [5:0] a, input [7:0] e);
  begin
    bus(1'b0, a, 8'h00);
    chk(rdat, e);
  end
  endtask
  task tstep(input s3, input [15:0] v, input integer n);
    repeat (n)
    begin
      @(posedge mclk);
      timer_one_count <= s3 ? 16'h0000 : v;
      timer_three_count <= s3 ? v : 16'h0000;
    end
  endtask
  // one-cycle period pulse, then two edges so the pin shows the new latch
  task pulse_period;
  begin
    @(posedge mclk);
    pwm_period_match <= 1'b1;
    @(posedge mclk);
    pwm_period_match <= 1'b0;
    repeat (2) @(posedge mclk);
  end
  endtask
  // compare value is 1234; the timer holds 1234 for four cycles to catch repeated actions
  task run_cmp(input [3:0] m, input s3, input lat, input ini, input fin, input ev);
  begin
    wr(6'h1C, {1'b0, s3, 6'h00});
    wr(6'h00, 8'h00);
    port_g_latch <= {1'b0, lat};
    wr(6'h00, {4'h0, m});
    wr(6'h2C, 8'h05);
    ev_cnt = 0;
    chk(chan_pin_out[0], ini);
    tstep(s3, 16'h1233, 1);
    tstep(s3, 16'h1234, 4);
    tstep(s3, 16'h1235, 3);
    chk(chan_pin_out[0], fin);
    chk(chan_irq[0], 1'b1);
    chk(ev_cnt, ev);
    rd(6'h2C, 8'h05);
    tstep(s3, 16'h0000, 1);
  end
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    {avs_read, avs_write, pwm_period_match} = 3'b000;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    {timer_one_count, timer_three_count} = 32'h00000000;
    pwm_timebase = 10'h000;
    port_g_direction = 2'b10;
    {port_g_latch, ext_level} = 4'h0;
    {error_cnt, check_count, ev_cnt} = 0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rd(6'h00, 8'h00);
    wr(6'h00, 8'hF0);
    rd(6'h00, 8'h30);
    wr(6'h30, 8'hFF);
    rd(6'h30, 8'h00);
    wr(6'h04, 8'h34);
    wr(6'h08, 8'h12);
    rd(6'h08, 8'h12);
    chk(chan_pin_oe_n, 2'b10);
    run_cmp(4'h8, 1'b0, 1'b0, 1'b0, 1'b1, 0);
    run_cmp(4'h8, 1'b1, 1'b0, 1'b0, 1'b1, 0);
    run_cmp(4'h2, 1'b0, 1'b0, 1'b0, 1'b1, 0);
    run_cmp(4'h9, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    run_cmp(4'hA, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    run_cmp(4'hB, 1'b0, 1'b1, 1'b1, 1'b1, 1);
    // pwm on chan4: duty 40 with fine bits 01, high byte read-only
    wr(6'h00, 8'h00);
    wr(6'h04, 8'h40);
    wr(6'h00, 8'h1C);
    wr(6'h08, 8'hFF);
    rd(6'h08, 8'h12);
    pulse_period;
    chk(chan_pin_out[0], 1'b1);
    rd(6'h08, 8'h40);
    pwm_timebase <= 10'h101;
    repeat (3) @(posedge mclk);
    chk(chan_pin_out[0], 1'b0);
    pwm_timebase <= 10'h000;
    pulse_period;
    chk(chan_pin_out[0], 1'b1);
    wr(6'h00, 8'h00);
    wr(6'h00, 8'h1C);
    repeat (2) @(posedge mclk);
    chk(chan_pin_out[0], 1'b0);
    wr(6'h2C, 8'h03);
    wr(6'h0C, 8'h05);
    // second capture overwrites the first value while its flag is still set
    for (i = 0; i < 2; i = i + 1)
    begin
      tstep(1'b0, i ? 16'h9ABC : 16'h5678, 1);
      ext_level <= 2'b00;
      repeat (6) @(posedge mclk);
      ext_level <= 2'b10;
      repeat (8) @(posedge mclk);
      rd(6'h10, i ? 8'hBC : 8'h78);
    end
    rd(6'h14, 8'h9A);
    rd(6'h2C, 8'h02);
    wr(6'h2C, 8'h08);
    rd(6'h2C, 8'h0A);
    chk(chan_irq, 2'b10);
    // every 4th rising edge: only the last of four edges captures
    wr(6'h0C, 8'h00);
    wr(6'h0C, 8'h06);
    for (i = 0; i < 4; i = i + 1)
    begin
      tstep(1'b0, {12'h111, i[3:0]}, 1);
      ext_level <= 2'b00;
      repeat (4) @(posedge mclk);
      ext_level <= 2'b10;
      repeat (6) @(posedge mclk);
      rd(6'h10, (i == 3) ? 8'h13 : 8'hBC);
    end
    wr(6'h28, 8'h01);
    wr(6'h24, 8'h10);
    rd(6'h24, 8'h10);
    rd(6'h20, 8'h00);
    wr(6'h28, 8'h00);
    tstep(1'b0, 16'hABCD, 1);
    rd(6'h24, 8'hAB);
    rd(6'h20, 8'hCD);
    results;
  end
endmodule // ccpc_top_tb
